// *** hdl/fexrg_pkg.sv ***
package fexrg_pkg;

  // Widths
  localparam int NPIN   = 8;
  localparam int AW     = 8;
  localparam int DW     = 32;
  localparam int RAM_AW = 4;
  localparam int RAM_N  = 16;

  // Register byte addresses
  localparam logic [AW-1:0] ADDR_CTRL      = 8'h00;
  localparam logic [AW-1:0] ADDR_STATUS    = 8'h04;
  localparam logic [AW-1:0] ADDR_WAKE_LOW  = 8'h08;
  localparam logic [AW-1:0] ADDR_WAKE_HIGH = 8'h0c;
  localparam logic [AW-1:0] ADDR_WAKE_TOG  = 8'h10;
  localparam logic [AW-1:0] ADDR_KEEP      = 8'h14;
  localparam logic [AW-1:0] ADDR_HOLD      = 8'h18;
  localparam logic [AW-1:0] ADDR_RAM_ADDR  = 8'h1c;
  localparam logic [AW-1:0] ADDR_RAM_DATA  = 8'h20;

  // Control register fields
  localparam int CTRL_REQ_BIT    = 0;
  localparam int CTRL_RETAIN_BIT = 1;
  localparam int CTRL_CLKSEL_BIT = 2;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_DONE_BIT  = 2;
  localparam int STAT_VALID_BIT = 3;
  localparam int STAT_SIG_BIT   = 4;
  localparam int STAT_TOG_BIT   = 5;
  localparam int STAT_CAP_LSB   = 8;

  // Reset values
  localparam logic            RETAIN_RST = 1'h1;
  localparam logic            CLKSEL_RST = 1'h0;
  localparam logic [NPIN-1:0] MASK_RST   = 8'h00;

  // Pin capabilities: pin 7 is output only, pins 6 and 7 serve the processor subsystem
  localparam logic [NPIN-1:0] PIN_INPUT_MASK  = 8'h7f;
  localparam logic [NPIN-1:0] PIN_PERIPH_MASK = 8'hc0;

  // Timing
  localparam int PCLK_HZ        = 50_000_000;
  localparam int SLOW_OSC_HZ    = 1_000_000;
  localparam int FAST_OSC_HZ    = 50_000_000;
  localparam int PCLK_PERIOD_NS = 1_000_000_000 / PCLK_HZ;
  localparam int SLOW_DIV       = PCLK_HZ / SLOW_OSC_HZ;
  localparam int FAST_DIV       = PCLK_HZ / FAST_OSC_HZ;
  localparam int EXIT_TIME_NS   = 100;
  localparam int EXIT_CYCLES    = (EXIT_TIME_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam logic [5:0] SLOW_LAST = 6'(SLOW_DIV - 1);
  localparam logic [5:0] FAST_LAST = 6'(FAST_DIV - 1);
  localparam logic [3:0] EXIT_LAST = 4'(EXIT_CYCLES - 1);

  typedef enum logic [1:0] {
    ST_RUN,
    ST_ENTER,
    ST_FROZEN,
    ST_EXIT
  } fexrg_state_e;

  typedef struct packed {
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata;
  } fexrg_apb_req_s;

  typedef struct packed {
    logic          pready;
    logic          pslverr;
    logic [DW-1:0] prdata;
  } fexrg_apb_rsp_s;

endpackage

// *** hdl/fexrg_ram.sv ***
`timescale 1ns/1ns
// Fabric block RAM model; contents have no reset and survive while en is low
module fexrg_ram
  import fexrg_pkg::*;
(
  input  wire logic              clk,     // Clock
  input  wire logic              en,      // Array powered and accessible
  input  wire logic              we,      // Write strobe
  input  wire logic [RAM_AW-1:0] addr,    // Word address
  input  wire logic [DW-1:0]     wdata,   // Write data
  output      logic [DW-1:0]     rdata_q  // Registered read data
);

  logic [DW-1:0] mem [RAM_N];

  // Array access only while enabled, so freeze leaves the contents alone
  always_ff @(posedge clk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata_q <= mem[addr];
    end
  end

endmodule

// *** hdl/fexrg_top.sv ***
`timescale 1ns/1ns
module fexrg_top
  import fexrg_pkg::*;
(
  input  wire logic            pclk,              // System clock, 50 MHz
  input  wire logic            presetn,           // Async reset, active low
  input  wire fexrg_apb_req_s  apb_req,           // APB request from master
  output      fexrg_apb_rsp_s  apb_rsp,           // APB response
  input  wire logic [NPIN-1:0] pin_in,            // Pad input levels
  input  wire logic [NPIN-1:0] func_out,          // Functional pad output value
  input  wire logic [NPIN-1:0] func_oe,           // Functional pad output enable
  output      logic [NPIN-1:0] pin_out,           // Pad output value
  output      logic [NPIN-1:0] pin_oe,            // Pad output enable, high drives
  output      logic            freeze_exit_done,  // High outside freeze, user reset gate
  output      logic            standby_clk_sel,   // 1 selects fast standby oscillator
  output      logic            standby_tick,      // Standby clock enable pulse
  output      logic            ram_contents_valid // Block RAM data may be trusted
);

  // All state of the block apart from the RAM array lives in one record: d is the next value, q the register.
  // Pad controls and the bus answer sit in it too, so every output leaves a flip-flop
  // and no combinational path runs from the bus or the pads to a top-level port.
  typedef struct packed {
    fexrg_state_e    st;
    logic            freeze_req;
    logic            ram_retain;
    logic            clk_sel;
    logic [NPIN-1:0] wake_low;
    logic [NPIN-1:0] wake_high;
    logic [NPIN-1:0] wake_tog;
    logic [NPIN-1:0] keep_func;
    logic [NPIN-1:0] hold_sel;
    logic [NPIN-1:0] cap;
    logic [NPIN-1:0] hold_out;
    logic [NPIN-1:0] hold_oe;
    logic            wake_sig;
    logic            wake_chg;
    logic            ram_valid;
    logic [RAM_AW-1:0] ram_addr;
    logic [3:0]      exit_cnt;
    logic [5:0]      div_cnt;
    logic            tick;
    logic [NPIN-1:0] pout;
    logic [NPIN-1:0] poe;
    logic            done;
    fexrg_apb_rsp_s  rsp;
  } fexrg_regs_s;

  fexrg_regs_s   q;
  fexrg_regs_s   d;
  // Combinational helpers
  logic [DW-1:0] ram_rdata;
  logic          ram_we;
  logic          wr_take;
  logic          setup;
  logic          addr_ok;
  logic          sig_match;
  logic          sig_used;
  logic          tog_hit;
  logic          frozen_io;
  logic [NPIN-1:0] eff_out;
  logic [NPIN-1:0] eff_oe;
  logic [DW-1:0] rd_val;
  logic [DW-1:0] status_w;
  logic [RAM_AW-1:0] ram_addr_nx;
  logic          run_st;

  // The word address is looked up one cycle early, so a read placed straight after
  // an address write already sees the new word; the array itself has no lookahead
  assign run_st      = (q.st == ST_RUN);
  assign ram_addr_nx = (wr_take && (apb_req.paddr == ADDR_RAM_ADDR)) ?
                       apb_req.pwdata[RAM_AW-1:0] : q.ram_addr;

  // Block RAM is only powered while running; contents stay put while disabled
  fexrg_ram u_ram (
    .clk     (pclk),
    .en      (run_st),
    .we      (ram_we),
    .addr    (ram_addr_nx),
    .wdata   (apb_req.pwdata),
    .rdata_q (ram_rdata)
  );

  // Bus phases; access always completes in one cycle after setup.
  // A write is taken only at the edge where the answer stands, and only when that
  // answer carries no error, so a refused write leaves every register untouched.
  assign setup   = apb_req.psel & ~apb_req.penable;
  assign wr_take = apb_req.psel & apb_req.penable & q.rsp.pready & apb_req.pwrite
                   & (q.st == ST_RUN) & ~q.rsp.pslverr;
  assign ram_we  = wr_take & (apb_req.paddr == ADDR_RAM_DATA);

  // Wake decision: signature needs at least one configured pin, else it would fire at once
  // Signature pins must all match in the same cycle; toggle pins are compared with
  // the levels captured on the way in, so either edge direction counts.
  assign sig_used  = |(q.wake_low | q.wake_high);
  assign sig_match = sig_used & ~|(q.wake_low & pin_in)
                     & ~|(q.wake_high & ~pin_in);
  assign tog_hit   = |((pin_in ^ q.cap) & q.wake_tog);

  // Pads stay frozen through the exit delay and are handed back one cycle after done rises
  assign frozen_io = (q.st == ST_FROZEN) || (q.st == ST_EXIT);

  // Per pin pad control while frozen. Priority: kept pins first, then wake inputs
  // (never driven, they listen), then the held or tristated rest.
  genvar gi;
  generate
    // One copy per pad; nothing is shared between pins
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      always_comb begin
        if (!frozen_io || q.keep_func[gi]) begin
          eff_out[gi] = func_out[gi];
          eff_oe[gi]  = func_oe[gi];
        end else if (q.wake_low[gi] || q.wake_high[gi] || q.wake_tog[gi]) begin
          eff_out[gi] = 1'b0;
          eff_oe[gi]  = 1'b0;
        end else if (q.hold_sel[gi]) begin
          eff_out[gi] = q.hold_out[gi];
          eff_oe[gi]  = q.hold_oe[gi];
        end else begin
          eff_out[gi] = 1'b0;
          eff_oe[gi]  = 1'b0;
        end
      end
    end
  endgenerate

  // Status word
  // Read only; software polls it to see why the block woke
  always_comb begin
    status_w = '0;
    status_w[STAT_STATE_LSB +: 2]    = q.st;
    status_w[STAT_DONE_BIT]          = q.done;
    status_w[STAT_VALID_BIT]         = q.ram_valid;
    status_w[STAT_SIG_BIT]           = q.wake_sig;
    status_w[STAT_TOG_BIT]           = q.wake_chg;
    status_w[STAT_CAP_LSB +: NPIN]   = q.cap;
  end

  // Read mux and address decode
  // Reads have no side effects, so a refused or repeated read is harmless
  always_comb begin
    addr_ok = 1'b1;
    rd_val  = '0;
    case (apb_req.paddr)
      ADDR_CTRL: begin
        rd_val[CTRL_REQ_BIT]    = q.freeze_req;
        rd_val[CTRL_RETAIN_BIT] = q.ram_retain;
        rd_val[CTRL_CLKSEL_BIT] = q.clk_sel;
      end
      ADDR_STATUS:    rd_val = status_w;
      ADDR_WAKE_LOW:  rd_val[NPIN-1:0] = q.wake_low;
      ADDR_WAKE_HIGH: rd_val[NPIN-1:0] = q.wake_high;
      ADDR_WAKE_TOG:  rd_val[NPIN-1:0] = q.wake_tog;
      ADDR_KEEP:      rd_val[NPIN-1:0] = q.keep_func;
      ADDR_HOLD:      rd_val[NPIN-1:0] = q.hold_sel;
      ADDR_RAM_ADDR:  rd_val[RAM_AW-1:0] = q.ram_addr;
      ADDR_RAM_DATA:  rd_val = q.ram_valid ? ram_rdata : '0;
      default:        addr_ok = 1'b0;
    endcase
  end

  // Next state
  always_comb begin
    d = q;
    d.tick = 1'b0;

    // Bus response is prepared in the setup cycle and shown in the access cycle
    // Outside a setup the answer is cleared, so ready is a single-cycle pulse
    d.rsp.pready  = setup;
    d.rsp.pslverr = 1'b0;
    d.rsp.prdata  = '0;
    if (setup) begin
      // Configuration is locked while frozen so pads cannot change under the user
      d.rsp.pslverr = ~addr_ok | (apb_req.pwrite & (q.st != ST_RUN));
      d.rsp.prdata  = apb_req.pwrite ? '0 : rd_val;
    end

    case (q.st)
      ST_RUN: begin
        // Done falls on the very edge that leaves RUN, before any pad is frozen
        d.done = 1'b1;
        if (q.freeze_req) begin
          d.st         = ST_ENTER;
          d.freeze_req = 1'b0;
          d.done       = 1'b0;
        end
      end
      ST_ENTER: begin
        // Capture levels before power is cut
        // Entry lasts one cycle; the standby divider restarts from zero
        d.cap      = pin_in;
        d.hold_out = func_out;
        d.hold_oe  = func_oe;
        d.wake_sig = 1'b0;
        d.wake_chg = 1'b0;
        d.div_cnt  = '0;
        d.st       = ST_FROZEN;
      end
      ST_FROZEN: begin
        // Standby clock enable from the chosen oscillator rate
        // In fast mode the last count is zero, so the tick stands every cycle
        if (q.div_cnt == (q.clk_sel ? FAST_LAST : SLOW_LAST)) begin
          d.div_cnt = '0;
          d.tick    = 1'b1;
        end else begin
          d.div_cnt = q.div_cnt + 6'h01;
        end
        // Both causes are recorded, so software can tell them apart after exit
        if (sig_match || tog_hit) begin
          d.wake_sig = sig_match;
          d.wake_chg = tog_hit;
          d.exit_cnt = '0;
          d.st       = ST_EXIT;
          // Sleeping arrays lose their words; the contents flag drops with the wake
          if (!q.ram_retain) begin
            d.ram_valid = 1'b0;
          end
        end
      end
      ST_EXIT: begin
        // Done rises only after the exit delay, so gated resets release cleanly
        // The counter is cleared at wake, so the delay is the same for every exit
        if (q.exit_cnt == EXIT_LAST) begin
          d.st   = ST_RUN;
          d.done = 1'b1;
        end else begin
          d.exit_cnt = q.exit_cnt + 4'h1;
        end
      end
      default: begin
        // Unreachable encodings fall back to running with done high
        d.st   = ST_RUN;
        d.done = 1'b1;
      end
    endcase

    // Software writes, after the hardware clear so a new request is not lost
    // Wake masks are cut to input-capable pins and the keep mask to peripheral pins,
    // so software cannot arm a pin the hardware could never honour.
    if (wr_take) begin
      case (apb_req.paddr)
        ADDR_CTRL: begin
          d.freeze_req = apb_req.pwdata[CTRL_REQ_BIT];
          d.ram_retain = apb_req.pwdata[CTRL_RETAIN_BIT];
          d.clk_sel    = apb_req.pwdata[CTRL_CLKSEL_BIT];
        end
        ADDR_WAKE_LOW:  d.wake_low  = apb_req.pwdata[NPIN-1:0] & PIN_INPUT_MASK;
        ADDR_WAKE_HIGH: d.wake_high = apb_req.pwdata[NPIN-1:0] & PIN_INPUT_MASK;
        ADDR_WAKE_TOG:  d.wake_tog  = apb_req.pwdata[NPIN-1:0] & PIN_INPUT_MASK;
        ADDR_KEEP:      d.keep_func = apb_req.pwdata[NPIN-1:0] & PIN_PERIPH_MASK;
        ADDR_HOLD:      d.hold_sel  = apb_req.pwdata[NPIN-1:0];
        ADDR_RAM_ADDR:  d.ram_addr  = apb_req.pwdata[RAM_AW-1:0];
        ADDR_RAM_DATA:  d.ram_valid = 1'b1;
        default:        d.ram_addr  = q.ram_addr;
      endcase
    end

    // Pad copies are registered here, one cycle behind the user's values
    d.pout = eff_out;
    d.poe  = eff_oe;
  end

  // State register; reset loads constants only, so release has no ordering hazard.
  // Done comes up high so that user resets behind it are free right after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q            <= '0;
      q.st         <= ST_RUN;
      q.ram_retain <= RETAIN_RST;
      q.clk_sel    <= CLKSEL_RST;
      q.wake_low   <= MASK_RST;
      q.wake_high  <= MASK_RST;
      q.wake_tog   <= MASK_RST;
      q.keep_func  <= MASK_RST;
      q.hold_sel   <= MASK_RST;
      q.ram_valid  <= 1'b0;
      q.done       <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  // No logic between register and port, so no glitch reaches user resets
  assign apb_rsp            = q.rsp;
  assign pin_out            = q.pout;
  assign pin_oe             = q.poe;
  assign freeze_exit_done   = q.done;
  assign standby_clk_sel    = q.clk_sel;
  assign standby_tick       = q.tick;
  assign ram_contents_valid = q.ram_valid;

endmodule

// *** tb/fexrg_chk.sv ***
`timescale 1ns/1ns
// Bus handshake and freeze sequencing seen at the top ports
module fexrg_chk
  import fexrg_pkg::*;
(
  input wire logic            pclk, // Clock
  input wire logic            presetn, // Reset
  input wire fexrg_apb_req_s  apb_req, // Request
  input wire fexrg_apb_rsp_s  apb_rsp, // Response
  input wire logic [NPIN-1:0] pin_in, // Pads in
  input wire logic [NPIN-1:0] func_out, // User value
  input wire logic [NPIN-1:0] func_oe, // User enable
  input wire logic [NPIN-1:0] pin_out, // Pad value
  input wire logic [NPIN-1:0] pin_oe, // Pad enable
  input wire logic            freeze_exit_done, // Exit done
  input wire logic            standby_clk_sel, // Fast clock
  input wire logic            standby_tick, // Tick
  input wire logic            ram_contents_valid // RAM valid
);
  logic [5:0] gap_q; // Cycles since last tick
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Restarts on each tick, so spacing needs no long repetition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 6'h00;
    end else begin
      gap_q <= freeze_exit_done ? 6'h00 : standby_tick ? 6'h01 : gap_q + {5'h00, |gap_q};
    end
  end
  pready_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no ready");
  unmapped_a: assert property (apb_req.psel && !apb_req.penable && apb_req.paddr > ADDR_RAM_DATA
    |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("hole accepted");
  tick_frozen_a: assert property (
    standby_tick |-> !freeze_exit_done && !$past(freeze_exit_done)) else $error("stray tick");
  tick_slow_a: assert property (
    standby_tick && !standby_clk_sel && |gap_q |-> gap_q == 6'h32) else $error("slow spacing");
  clksel_a: assert property (!freeze_exit_done |-> $stable(standby_clk_sel))
    else $error("clock choice moved");
  exit_len_a: assert property ($rose(freeze_exit_done) |-> !$past(freeze_exit_done, 7))
    else $error("exit too short");
  ram_drop_a: assert property ($fell(ram_contents_valid) |-> !$past(freeze_exit_done))
    else $error("ram lost in run");
  ram_set_a: assert property ($rose(ram_contents_valid) |-> $past(apb_req.pwrite)
    && $past(apb_req.penable) && $past(apb_req.paddr) == ADDR_RAM_DATA) else $error("ram set");
  cover property ($rose(freeze_exit_done));
  cover property (standby_tick && standby_clk_sel);
  cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule

// *** tb/fexrg_user.sv ***
`timescale 1ns/1ns
// User fabric: pad drivers and conditioner reset behind freeze_exit_done
module fexrg_user
  import fexrg_pkg::*;
(
  input  wire logic            pclk, // Clock
  input  wire logic            presetn, // Reset
  input  wire logic            freeze_exit_done, // Exit done
  output      logic [NPIN-1:0] func_out, // Pad values
  output      logic [NPIN-1:0] func_oe, // Pad enables
  output      logic            pll_async_reset_n // Conditioner reset
);
  logic       fab_rst_n;
  logic [5:0] cnt_q;
  logic [1:0] uart_q;
  assign pll_async_reset_n = ~freeze_exit_done;
  // Ungated, exit glitches would reset fabric state at random
  assign fab_rst_n = presetn & freeze_exit_done;
  assign func_out  = {uart_q, cnt_q};
  assign func_oe   = 8'hff;
  // Fabric counter, cleared while freeze is not done
  always_ff @(posedge pclk or negedge fab_rst_n) begin
    if (!fab_rst_n) cnt_q <= 6'h00;
    else cnt_q <= cnt_q + 6'h01;
  end
  // Serial lines stay live through freeze
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) uart_q <= 2'h0;
    else uart_q <= uart_q + 2'h1;
  end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
// Bus master and pad driver; a monitor scores each bus answer in order
module tb_top
  import fexrg_pkg::*;
();
  logic            pclk, presetn, done, sel, tick, valid;
  fexrg_apb_req_s  req;
  fexrg_apb_rsp_s  rsp;
  logic [NPIN-1:0] pin_in, func_out, func_oe, pin_out, pin_oe, fo_prev;
  logic [DW-1:0]   seed;
  logic [64:0]     note;
  logic [64:0]     exp_q[$];
  int              num_errors, n_checks, k, n;
  fexrg_top i_fexrg_top (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .pin_in(pin_in), .func_out(func_out), .func_oe(func_oe), .pin_out(pin_out), .pin_oe(pin_oe),
    .freeze_exit_done(done), .standby_clk_sel(sel), .standby_tick(tick),
    .ram_contents_valid(valid));
  fexrg_user i_fexrg_user (.pclk(pclk), .presetn(presetn), .freeze_exit_done(done),
    .func_out(func_out), .func_oe(func_oe), .pll_async_reset_n());
  function automatic logic [DW-1:0] lfsr(input logic [DW-1:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic complete_run;
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic c, input string s);
    n_checks++;
    if (c !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, s);
    end
  endtask
  // One transfer, held until ready is sampled; the note goes first
  task automatic xf(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
                    input logic [64:0] e);
    int i;
    exp_q.push_back(e);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      if (rsp.pready === 1'b1) break;
    end
    if (i == 8) begin
      chk(1'b0, "bus hang");
      complete_run();
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    xf(1'b1, a, d, 65'h0);
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] x, input logic [DW-1:0] m);
    xf(1'b0, a, 32'h0, {1'b0, x, m});
  endtask
  // Releases the bus, then waits a bounded time for the done level
  task automatic wd(input logic v);
    int i;
    req <= '0;
    for (i = 0; i < 200; i++) begin
      @(posedge pclk);
      if (done === v) break;
    end
    if (i == 200) begin
      chk(1'b0, "freeze hang");
      complete_run();
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) fo_prev <= func_out;
  // Scores every answer against the oldest note
  always @(posedge pclk) begin
    if (rsp.pready === 1'b1) begin
      note = exp_q.size() > 0 ? exp_q.pop_front() : '1;
      chk(rsp.pslverr === note[64] && (rsp.prdata & note[31:0]) === note[63:32], "bus answer");
    end
  end
  initial begin
    presetn = 1'b0;
    req = '0;
    pin_in = 8'h00;
    seed = lfsr(32'h0c681fdf);
    num_errors = 0;
    n_checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_CTRL, 32'h2, 32'h7);
    rd(ADDR_STATUS, 32'h4, 32'hf);
    xf(1'b0, 8'h40, 32'h0, {1'b1, 32'h0, 32'hffffffff});
    for (k = 0; k < 3; k++) begin
      wr(ADDR_WAKE_LOW + 8'(k * 4), 32'hff);
      rd(ADDR_WAKE_LOW + 8'(k * 4), 32'h7f, 32'hff);
    end
    wr(ADDR_KEEP, 32'hff);
    rd(ADDR_KEEP, 32'hc0, 32'hff);
    wr(ADDR_WAKE_LOW, 32'h0);
    wr(ADDR_WAKE_HIGH, 32'h0);
    wr(ADDR_WAKE_TOG, 32'h1);
    wr(ADDR_HOLD, 32'h8);
    wr(ADDR_RAM_ADDR, 32'h3);
    wr(ADDR_RAM_DATA, seed);
    // Fast standby clock, retained RAM, pad 0 toggle wakes
    wr(ADDR_CTRL, 32'h7);
    wd(1'b0);
    repeat (4) @(posedge pclk);
    chk(pin_oe === 8'hc8, "frozen enables");
    chk(pin_out[7:6] === fo_prev[7:6], "kept pads");
    chk(tick === 1'b1 && sel === 1'b1, "fast tick");
    xf(1'b1, ADDR_CTRL, 32'h0, {1'b1, 64'h0});
    pin_in <= 8'h01;
    wd(1'b1);
    rd(ADDR_STATUS, 32'h2c, 32'hff3f);
    rd(ADDR_RAM_DATA, seed, 32'hffffffff);
    // Slow clock, sleeping RAM, pad 1 low and pad 2 high wake
    wr(ADDR_WAKE_TOG, 32'h0);
    wr(ADDR_WAKE_LOW, 32'h2);
    wr(ADDR_WAKE_HIGH, 32'h4);
    wr(ADDR_CTRL, 32'h1);
    wd(1'b0);
    pin_in <= 8'h00;
    n = 0;
    for (k = 0; k < 120; k++) begin
      @(posedge pclk);
      if (tick === 1'b1) n++;
    end
    chk(n == 2 && done === 1'b0, "slow tick or early wake");
    pin_in <= 8'h04;
    wd(1'b1);
    rd(ADDR_STATUS, 32'h114, 32'hff3f);
    rd(ADDR_RAM_DATA, 32'h0, 32'hffffffff);
    req <= '0;
    repeat (2) @(posedge pclk);
    complete_run();
  end
endmodule
bind fexrg_top fexrg_chk i_fexrg_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .pin_in(pin_in), .func_out(func_out), .func_oe(func_oe), .pin_out(pin_out),
  .pin_oe(pin_oe), .freeze_exit_done(freeze_exit_done), .standby_clk_sel(standby_clk_sel),
  .standby_tick(standby_tick), .ram_contents_valid(ram_contents_valid));
